// ==== design/asdr_port.sv ====
// serial port and data-ready output of the converter
`timescale 1ns/1ps
module asdr_port
  import asdr_pkg::*;
#(
  parameter int unsigned RES_W = asdr_pkg::RESULT_W
) (
  input wire logic MCLK_I,
  input wire logic ARST_N_I,
  input wire logic CE_I,
  input wire logic SELECT_N_I,
  input wire logic SCLK_I,
  input wire logic SDI_I,
  output logic SDO_O,
  output logic SDO_OE_O,
  output logic RESULT_READY_N_O,
  input wire logic HARD_RESET_N_I,
  input wire logic GP_OR_EXT_CLOCK_PIN_I,
  input wire logic EXT_CLK_MODE_I,
  input wire logic [RES_W-1:0] RESULT_I,
  input wire logic RESULT_VALID_I
);
  import asdr_pkg::*;

  if (RES_W < 2) begin : g_bad_width
    $error("result width must be at least two");
  end

  ////////////////////////////////////////////////////////////////////////
  // synchronised pins: select, serial clock, data in, reset, ext clock
  logic [4:0] pin_raw;
  logic [4:0] pin_s2;
  logic [4:0] pin_s3;
  assign pin_raw = {GP_OR_EXT_CLOCK_PIN_I, HARD_RESET_N_I, SDI_I, SCLK_I, SELECT_N_I};

  asdr_sync #(.W(5), .RST_V(PIN_IDLE)) u_sync (
    .clk_i(MCLK_I),
    .arst_n_i(ARST_N_I),
    .ce_i(CE_I),
    .d_i(pin_raw),
    .s2_o(pin_s2),
    .s3_o(pin_s3)
  );

  // filtered levels change only once stages two and three agree
  logic [4:0] lvl_q;
  logic [4:0] lvl_d;
  always_comb begin
    lvl_d = lvl_q;
    if (CE_I) begin
      for (int i = 0; i < 5; i++) begin
        if (pin_s2[i] == pin_s3[i]) lvl_d[i] = pin_s3[i];
      end
    end
  end

  logic sel_n;
  logic sclk;
  logic sdi;
  logic hrst_n;
  logic xclk;
  assign sel_n = lvl_q[0];
  assign sclk = lvl_q[1];
  assign sdi = lvl_q[2];
  assign hrst_n = lvl_q[3];
  assign xclk = lvl_q[4];

  logic sclk_rise;
  logic sclk_fall;
  logic sel_fall;
  logic hrst_fall;
  logic xclk_rise;
  assign sclk_rise = CE_I && !sclk && lvl_d[1] && !lvl_d[0];
  assign sclk_fall = CE_I && sclk && !lvl_d[1] && !lvl_d[0];
  assign sel_fall = CE_I && sel_n && !lvl_d[0];
  assign hrst_fall = CE_I && hrst_n && !lvl_d[3];
  assign xclk_rise = CE_I && !xclk && lvl_d[4];

  ////////////////////////////////////////////////////////////////////////
  // frame state
  typedef enum logic [2:0] {
    ASDR_IDLE = 3'b001,
    ASDR_CMD = 3'b010,
    ASDR_DATA = 3'b100
  } asdr_state_e;

  localparam int unsigned CW = $clog2(RES_W + 1);
  localparam int unsigned RW = $clog2(RST_RDY_CYC + 1);

  asdr_state_e st_q;
  asdr_state_e st_d;
  logic [CMD_W-1:0] cmd_q;
  logic [CMD_W-1:0] cmd_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [RES_W-1:0] hold_q;
  logic [RES_W-1:0] hold_d;
  logic [RES_W-1:0] shf_q;
  logic [RES_W-1:0] shf_d;
  logic sdo_q;
  logic sdo_d;
  logic ready_n_q;
  logic ready_n_d;
  logic [RW-1:0] rst_cnt_q;
  logic [RW-1:0] rst_cnt_d;
  logic [1:0] xcnt_q;
  logic [1:0] xcnt_d;
  logic rst_pend_q;
  logic rst_pend_d;

  always_comb begin
    st_d = st_q;
    cmd_d = cmd_q;
    cnt_d = cnt_q;
    hold_d = hold_q;
    shf_d = shf_q;
    sdo_d = sdo_q;
    ready_n_d = ready_n_q;
    rst_cnt_d = rst_cnt_q;
    xcnt_d = xcnt_q;
    rst_pend_d = rst_pend_q;
    if (CE_I) begin
      if (RESULT_VALID_I) begin
        hold_d = RESULT_I;
        ready_n_d = 1'b0;
      end
      if (lvl_d[0]) begin
        st_d = ASDR_IDLE;
        cnt_d = '0;
      end else if (sel_fall) begin
        st_d = ASDR_CMD;
        cnt_d = '0;
      end else begin
        unique case (st_q)
          ASDR_IDLE: begin
          end
          ASDR_CMD: begin
            if (sclk_rise) begin
              cmd_d = {cmd_q[CMD_W-2:0], sdi};
              if (cnt_q == CW'(CMD_W - 1)) begin
                cnt_d = '0;
                if ({cmd_q[CMD_W-2:0], sdi} == READ_CMD) begin
                  st_d = ASDR_DATA;
                  shf_d = hold_q;
                end else begin
                  st_d = ASDR_IDLE;
                end
              end else begin
                cnt_d = cnt_q + CW'(1);
              end
            end
          end
          ASDR_DATA: begin
            if (sclk_fall && cnt_q < CW'(RES_W)) begin
              sdo_d = shf_q[RES_W-1];
              shf_d = {shf_q[RES_W-2:0], 1'b0};
              cnt_d = cnt_q + CW'(1);
            end
            // bits placed so far equal RES_W-1 means LSB+1 now on the line
            if (sclk_rise && cnt_q == CW'(RES_W - 1) && !RESULT_VALID_I) begin
              ready_n_d = 1'b1;
            end
          end
          default: st_d = ASDR_IDLE;
        endcase
      end
      if (hrst_fall) begin
        rst_pend_d = 1'b1;
        rst_cnt_d = '0;
        xcnt_d = '0;
      end else if (rst_pend_q) begin
        if (EXT_CLK_MODE_I) begin
          if (xclk_rise) xcnt_d = xcnt_q + 2'd1;
          // the sync delay stands in for the last external period
          if (xclk_rise && xcnt_q == 2'(EXT_CLK_PERIODS - 2)) begin
            ready_n_d = 1'b1;
            rst_pend_d = 1'b0;
          end
        end else begin
          rst_cnt_d = rst_cnt_q + RW'(1);
          // sync, filter and output flops use part of the budget
          if (rst_cnt_q >= RW'(RST_RDY_CYC - SYNC_STAGES - 3)) begin
            ready_n_d = 1'b1;
            rst_pend_d = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      lvl_q <= PIN_IDLE;
      st_q <= ASDR_IDLE;
      cmd_q <= '0;
      cnt_q <= '0;
      hold_q <= RES_W'(RESULT_RST);
      shf_q <= '0;
      sdo_q <= 1'b0;
      ready_n_q <= 1'b1;
      rst_cnt_q <= '0;
      xcnt_q <= '0;
      rst_pend_q <= 1'b0;
    end else begin
      lvl_q <= lvl_d;
      st_q <= st_d;
      cmd_q <= cmd_d;
      cnt_q <= cnt_d;
      hold_q <= hold_d;
      shf_q <= shf_d;
      sdo_q <= sdo_d;
      ready_n_q <= ready_n_d;
      rst_cnt_q <= rst_cnt_d;
      xcnt_q <= xcnt_d;
      rst_pend_q <= rst_pend_d;
    end
  end

  assign RESULT_READY_N_O = ready_n_q;
  assign SDO_O = sdo_q;
  assign SDO_OE_O = !sel_n;
endmodule : asdr_port

// ==== design/asdr_pkg.sv ====
// shared constants for the converter serial port and data-ready logic
package asdr_pkg;
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned RESULT_W = 24;
  localparam int unsigned CMD_W = 8;
  localparam int unsigned RST_RDY_MAX_NS = 300;
  localparam int unsigned RST_RDY_CYC = (RST_RDY_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned EXT_CLK_PERIODS = 2;
  localparam logic [7:0] READ_CMD = 8'hc1;
  localparam logic [23:0] RESULT_RST = 24'h000000;
  localparam int unsigned SYNC_STAGES = 3;
  // idle pin levels: ext clock high, reset high, data low, sclk low, select high
  localparam logic [4:0] PIN_IDLE = 5'h19;
endpackage : asdr_pkg

// ==== design/asdr_sync.sv ====
// three-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module asdr_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_V = '0
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] s2_o,
  output logic [W-1:0] s3_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] s1_d;
  logic [W-1:0] s2_d;
  logic [W-1:0] s3_d;

  if (W < 1) begin : g_bad_width
    $error("width must be at least one");
  end

  always_comb begin
    s1_d = ce_i ? d_i : s1_q;
    s2_d = ce_i ? s1_q : s2_q;
    s3_d = ce_i ? s2_q : s3_q;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // reset to the idle levels so no false edge follows reset
      s1_q <= RST_V;
      s2_q <= RST_V;
      s3_q <= RST_V;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  assign s2_o = s2_q;
  assign s3_o = s3_q;
endmodule : asdr_sync

// ==== tb/asdr_port_chk.sv ====
// assertions on the serial port and ready pins
`timescale 1ns/1ps
module asdr_port_chk (
  input wire logic MCLK_I,
  input wire logic ARST_N_I,
  input wire logic CE_I,
  input wire logic SELECT_N_I,
  input wire logic SCLK_I,
  input wire logic SDO_O,
  input wire logic SDO_OE_O,
  input wire logic RESULT_READY_N_O,
  input wire logic HARD_RESET_N_I,
  input wire logic EXT_CLK_MODE_I,
  input wire logic RESULT_VALID_I
);
  localparam int RMAX = 75;
  localparam int XMAX = 32;
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!ARST_N_I);
  rdy_set_a: assert property (CE_I && RESULT_VALID_I |=> !RESULT_READY_N_O) else $error("ready late");
  rdy_hold_a: assert property (!RESULT_READY_N_O && SELECT_N_I && HARD_RESET_N_I
    |=> !RESULT_READY_N_O) else $error("ready lost");
  rdy_rise_a: assert property ($rose(RESULT_READY_N_O) && !SELECT_N_I
    |-> $past(SCLK_I, 3)) else $error("ready rise edge");
  rst_int_a: assert property ($fell(HARD_RESET_N_I) && !EXT_CLK_MODE_I
    |-> ##[1:RMAX] RESULT_READY_N_O) else $error("int reset slow");
  rst_ext_a: assert property ($fell(HARD_RESET_N_I) && EXT_CLK_MODE_I
    |-> ##[1:XMAX] RESULT_READY_N_O) else $error("ext reset slow");
  sdo_fall_a: assert property ($changed(SDO_O) && $past(SDO_OE_O) && SDO_OE_O
    |-> !$past(SCLK_I, 3)) else $error("sdo edge");
  oe_off_a: assert property (SELECT_N_I [*6] |-> !SDO_OE_O) else $error("oe stuck");
  oe_on_a: assert property (!SELECT_N_I [*6] |-> SDO_OE_O) else $error("oe missing");
  cover property ($rose(RESULT_READY_N_O) && !SELECT_N_I);
  cover property ($fell(HARD_RESET_N_I) && EXT_CLK_MODE_I);
  cover property (RESULT_VALID_I);
endmodule : asdr_port_chk
bind asdr_port asdr_port_chk chk (.MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I), .CE_I(CE_I),
  .SELECT_N_I(SELECT_N_I), .SCLK_I(SCLK_I), .SDO_O(SDO_O), .SDO_OE_O(SDO_OE_O),
  .RESULT_READY_N_O(RESULT_READY_N_O), .HARD_RESET_N_I(HARD_RESET_N_I),
  .EXT_CLK_MODE_I(EXT_CLK_MODE_I), .RESULT_VALID_I(RESULT_VALID_I));

// ==== tb/asdr_host.sv ====
// host controller model making mode 0 frames
`timescale 1ns/1ps
module asdr_host (
  input wire logic clk_i,
  input wire logic sdo_i,
  input wire logic sdo_oe_i,
  output logic select_n_o = 1'b1,
  output logic sclk_o = 1'b0,
  output logic sdi_o = 1'b0
);
  task automatic half;
    repeat (6) @(negedge clk_i);
  endtask : half
  task automatic frame(input logic [7:0] cmd, output logic [23:0] res);
    @(negedge clk_i);
    select_n_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sdi_o = cmd[i];
      half();
      sclk_o = 1'b1;
      // change data inside the high phase: only the rise may capture it
      repeat (3) @(negedge clk_i);
      sdi_o = ~cmd[i];
      repeat (3) @(negedge clk_i);
      sclk_o = 1'b0;
    end
    for (int i = 23; i >= 0; i--) begin
      half();
      sclk_o = 1'b1;
      // a released line shows the inverse of the driven bit
      res[i] = sdo_oe_i ? sdo_i : ~sdo_i;
      half();
      sclk_o = 1'b0;
    end
    half();
    select_n_o = 1'b1;
    half();
  endtask : frame
endmodule : asdr_host

// ==== tb/asdr_port_test.sv ====
// self-checking bench for the serial port
`timescale 1ns/1ps
module asdr_port_test;
  import asdr_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hrst_n = 1'b1;
  logic xclk = 1'b0;
  logic xmode = 1'b0;
  logic vld = 1'b0;
  logic ce = 1'b1;
  logic [23:0] res = 24'h000000;
  logic [23:0] got;
  logic sel_n, sclk, sdi, sdo, oe, rdy_n;
  int error_cnt = 0;
  int n_checks = 0;
  always #2 clk = ~clk;
  always #32 xclk = ~xclk;
  asdr_port uut (.MCLK_I(clk), .ARST_N_I(arst_n), .CE_I(ce), .SELECT_N_I(sel_n),
    .SCLK_I(sclk), .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_O(oe), .RESULT_READY_N_O(rdy_n),
    .HARD_RESET_N_I(hrst_n), .GP_OR_EXT_CLOCK_PIN_I(xclk), .EXT_CLK_MODE_I(xmode),
    .RESULT_I(res), .RESULT_VALID_I(vld));
  asdr_host host (.clk_i(clk), .sdo_i(sdo), .sdo_oe_i(oe), .select_n_o(sel_n),
    .sclk_o(sclk), .sdi_o(sdi));
  task automatic chk(input logic [23:0] a, input logic [23:0] e);
    n_checks++;
    if (a !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got %h exp %h", $time, a, e);
    end
  endtask : chk
  task automatic load(input logic [23:0] v);
    @(negedge clk);
    res = v;
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
    @(negedge clk);
    chk(rdy_n, 1'b0);
  endtask : load
  task automatic t_read(input logic [23:0] v);
    load(v);
    host.frame(READ_CMD, got);
    chk(got, v);
    chk(rdy_n, 1'b1);
    chk(oe, 1'b0);
    $display("read %h done", v);
  endtask : t_read
  task automatic t_ce;
    @(negedge clk);
    ce = 1'b0;
    res = 24'h0f0f0f;
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
    @(negedge clk);
    chk(rdy_n, 1'b1);
    ce = 1'b1;
    @(negedge clk);
    chk(rdy_n, 1'b1);
    $display("clock enable done");
  endtask : t_ce
  task automatic t_bad;
    load(24'h5a5a5a);
    host.frame(8'h41, got);
    chk(rdy_n, 1'b0);
    $display("bad command done");
  endtask : t_bad
  task automatic t_rst(input logic m, input int lim);
    int n = 0;
    xmode = m;
    load(24'h123456);
    hrst_n = 1'b0;
    while (rdy_n !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk(rdy_n, 1'b1);
    repeat (100) @(negedge clk);
    hrst_n = 1'b1;
    repeat (8) @(negedge clk);
    $display("reset mode %0d done", m);
  endtask : t_rst
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  initial begin
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    repeat (8) @(negedge clk);
    t_read(24'h800001);
    t_read(24'h7ffffe);
    t_ce();
    t_bad();
    t_rst(1'b0, 75);
    t_rst(1'b1, 32);
    finish_test();
  end
  initial begin
    #50000;
    error_cnt++;
    finish_test();
  end
endmodule : asdr_port_test
